// File: rtl/mpcr_pkg.sv
// Constants, types and register layout for the MCU power and system control block.
// Assumes a single 100 MHz core clock and the core's byte-wide data-space access port.
// How it works
// [RL1] Sleep instruction acts only with sleep enable set
// [RL2] Software sets enable before sleep, clears after
// [RL3] Control register at data 0x55, I/O 0x35
// [RL4] Debug-port disable bit overrides the enabling fuse
// [RL5] Debug disable changes on two equal writes
// [RL6] Brown-out sleep bit needs unlock write first
// [RL7] Brown-out sleep effective three cycles after set
// [RL8] Brown-out sleep bit self-clears after three cycles
// [RL9] Global pull-up off overrides every pin setting
// [RL10] Vector select picks flash start or boot
// [RL11] Vector select changes only after unlock write
// [RL12] Interrupts blocked during the vector change sequence
// [RL13] Vector unlock clears after four cycles or select
// [RL14] Boot lock bits block interrupts by section
// [RL15] Clock gate register stops one peripheral per bit
// [RL16] Timer two stops only in synchronous mode
// [RL17] Stopped timers resume from their frozen state
// [RL18] Software reinitialises serial blocks after wake
// [RL19] Converter stopped also denies comparator the mux
// [RL20] Reset returns every register to its initial value
// [RL21] Port reset acts at once without clock
// [RL22] Internal reset stretched by fuse-selected time-out
// [RL23] Sleep select codes map to six modes
// [RL24] Unused control bits read zero, ignore writes
package mpcr_pkg;

    // Address map
    localparam logic [7:0] IO_TO_DATA_OFS  = 8'h20;
    localparam logic [7:0] SLEEP_CTRL_ADDR = 8'h53;
    localparam logic [7:0] MCU_CTRL_ADDR   = 8'h55;
    localparam logic [7:0] CLK_GATE_ADDR   = 8'h64;
    localparam logic [7:0] IO_SPACE_SIZE   = 8'h40;

    // Sleep control fields
    localparam int SC_ENABLE_BIT = 0;
    localparam int SC_MODE_LSB   = 1;
    localparam int SC_MODE_MSB   = 3;
    localparam logic [3:0] SLEEP_CTRL_RESET = 4'h0;

    // mcu_control fields
    localparam int MC_DBG_OFF    = 7;
    localparam int MC_BROWN_OFF  = 6;
    localparam int MC_BROWN_UNLK = 5;
    localparam int MC_PULL_OFF   = 4;
    localparam int MC_VSEL       = 1;
    localparam int MC_VUNLK      = 0;

    // peripheral_clock_gate fields
    localparam int CG_TIMER_TWO  = 6;
    localparam logic [7:0] CLK_GATE_RESET = 8'h00;

    // Timed sequences, in core clock cycles
    localparam int unsigned UNLOCK_CYC      = 4;
    localparam int unsigned BROWN_DELAY_CYC = 3;
    localparam logic [1:0]  BROWN_LIFE_LAST = 2'h2;

    // Reset time-out choices
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TOUT_FAST_CK  = 6;
    localparam int unsigned TOUT_SHORT_MS = 4;
    localparam int unsigned TOUT_LONG_MS  = 65;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam logic [1:0]  TOUT_SEL_FAST  = 2'h0;
    localparam logic [1:0]  TOUT_SEL_SHORT = 2'h1;

    typedef enum logic [2:0] {
        MPCR_SLEEP_IDLE      = 3'h0,
        MPCR_SLEEP_NOISE_RED = 3'h1,
        MPCR_SLEEP_PWR_DOWN  = 3'h2,
        MPCR_SLEEP_PWR_SAVE  = 3'h3,
        MPCR_SLEEP_RSVD_A    = 3'h4,
        MPCR_SLEEP_RSVD_B    = 3'h5,
        MPCR_SLEEP_STANDBY   = 3'h6,
        MPCR_SLEEP_EXT_STBY  = 3'h7
    } mpcr_sleep_e;

    typedef enum logic [2:0] {
        MPCR_VEC_IDLE  = 3'h1,
        MPCR_VEC_ARMED = 3'h2,
        MPCR_VEC_HOLD  = 3'h4
    } mpcr_vec_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       io_space;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } mpcr_bus_s;

    typedef struct packed {
        logic       debug_port_fuse;
        logic       app_protect_lock;
        logic       boot_protect_lock;
        logic [1:0] startup_sel;
    } mpcr_fuse_s;

endpackage

// File: rtl/mpcr_window.sv
// Timed unlock window: opens for LEN cycles on start, closes early on stop.
// Assumes start and stop are single-cycle pulses on the core clock.
`timescale 1ns/1ns
module mpcr_window
    import mpcr_pkg::*;
#(
    parameter int unsigned LEN = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Control
    input  wire logic start,
    input  wire logic stop,
    // Status
    output logic      open
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // Start beats stop so a fresh unlock in the closing cycle is kept
    always_comb begin
        if (start) begin
            cnt_next = 4'(LEN);
        end else if (stop || cnt_reg == 4'h0) begin
            cnt_next = 4'h0;
        end else begin
            cnt_next = cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign open = (cnt_reg != 4'h0);
endmodule

// File: rtl/mpcr_rst_stretch.sv
// Internal reset stretcher: holds core reset after all sources release.
// Assumes rst_b already merges every reset source asynchronously.
`timescale 1ns/1ns
module mpcr_rst_stretch
    import mpcr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Time-out choice
    input  wire logic [1:0]  sel,
    input  wire logic [31:0] short_cyc,
    input  wire logic [31:0] long_cyc,
    // Stretched reset
    output logic             core_rst_b
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        done_reg;
    logic        done_next;
    logic [31:0] target;

    // Fuse level read by clocked logic only, never by the async reset
    always_comb begin
        if (sel == TOUT_SEL_FAST) begin
            target = TOUT_FAST_CK;
        end else if (sel == TOUT_SEL_SHORT) begin
            target = short_cyc;
        end else begin
            target = long_cyc;
        end
        cnt_next  = cnt_reg;
        done_next = done_reg;
        if (!done_reg) begin
            cnt_next  = cnt_reg + 32'h1;
            done_next = (cnt_next >= target); // [RL22]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg  <= 32'h0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign core_rst_b = done_reg;
endmodule

// File: rtl/mpcr_top.sv
// System control registers: sleep control, mcu_control and peripheral_clock_gate.
// Assumes the core presents one byte access per cycle and pulses sleep_instr and
// instr_retire; rst_b is the merged, asynchronous, active-low reset source.
`timescale 1ns/1ns
module mpcr_top
    import mpcr_pkg::*;
#(
    parameter int unsigned TOUT_SHORT_CYC = TOUT_SHORT_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int unsigned TOUT_LONG_CYC  = TOUT_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Core register access
    input  wire mpcr_bus_s   bus,
    output logic [7:0]       rd_data,
    // Core status
    input  wire logic        sleep_instr,
    input  wire logic        instr_retire,
    input  wire logic        exec_in_boot,
    // Fuses and straps
    input  wire mpcr_fuse_s  fuse,
    input  wire logic        timer_two_async_select,
    // Sleep
    output logic             sleep_go,
    output mpcr_sleep_e      sleep_mode,
    output logic             brownout_sleep_off,
    // System controls
    output logic             debug_port_enable,
    output logic             pullup_global_off,
    output logic             vector_table_select,
    output logic             irq_block,
    // Peripheral clocks
    output logic [7:0]       clock_stop,
    output logic             comparator_mux_ok,
    // Resets
    output logic             core_rst_b,
    output logic             port_rst_b
);
    logic [7:0] data_addr;
    logic       wr_sc;
    logic       wr_mc;
    logic       wr_cg;
    logic [7:0] wd;
    logic       dbg_open;
    logic       brown_open;
    logic       vunlk_open;
    logic       dbg_start;
    logic       dbg_done;
    logic       brown_start;
    logic       brown_set;
    logic       vunlk_start;
    logic       vsel_write;
    logic [7:0] gate_eff;

    logic [3:0]                   sleep_ctrl_reg,  sleep_ctrl_next;
    logic                         dbg_off_reg,     dbg_off_next;
    logic                         dbg_pend_reg,    dbg_pend_next;
    logic                         brown_off_reg,   brown_off_next;
    logic [1:0]                   brown_age_reg,   brown_age_next;
    logic [BROWN_DELAY_CYC-1:0]   brown_pipe_reg,  brown_pipe_next;
    logic                         pull_off_reg,    pull_off_next;
    logic                         vsel_reg,        vsel_next;
    mpcr_vec_state_e              vec_state_reg,   vec_state_next;
    logic [7:0]                   gate_reg,        gate_next;
    logic [7:0]                   rd_data_reg,     rd_data_next;
    logic                         sleep_go_reg,    sleep_go_next;
    logic                         brown_sleep_reg, brown_sleep_next;
    logic                         dbg_en_reg,      dbg_en_next;
    logic                         irq_block_reg,   irq_block_next;
    logic [7:0]                   clk_stop_reg,    clk_stop_next;
    logic                         cmp_ok_reg,      cmp_ok_next;
    logic                         port_rst_reg;

    // I/O form sits 0x20 lower and cannot reach the extended space
    assign data_addr = !bus.io_space ? bus.addr
                     : bus.addr < IO_SPACE_SIZE ? 8'(bus.addr + IO_TO_DATA_OFS) : 8'h00; // [RL3]
    assign wd        = bus.wdata;
    assign wr_sc     = bus.wr && data_addr == SLEEP_CTRL_ADDR;
    assign wr_mc     = bus.wr && data_addr == MCU_CTRL_ADDR; // [RL3]
    assign wr_cg     = bus.wr && data_addr == CLK_GATE_ADDR; // [RL15]

    // Second equal write inside the window commits, anything else re-arms
    assign dbg_done    = wr_mc && dbg_open && (wd[MC_DBG_OFF] == dbg_pend_reg); // [RL5]
    assign dbg_start   = wr_mc && !dbg_done;
    assign brown_start = wr_mc && wd[MC_BROWN_OFF] && wd[MC_BROWN_UNLK]; // [RL6]
    assign brown_set   = wr_mc && brown_open && wd[MC_BROWN_OFF] && !wd[MC_BROWN_UNLK];
    assign vunlk_start = wr_mc && wd[MC_VUNLK]; // [RL11]
    assign vsel_write  = wr_mc && vunlk_open && !wd[MC_VUNLK]; // [RL11]

    mpcr_window #(.LEN(UNLOCK_CYC)) u_dbg_win (
        .clk   (clk),
        .rst_b (rst_b),
        .start (dbg_start),
        .stop  (dbg_done),
        .open  (dbg_open)
    );

    mpcr_window #(.LEN(UNLOCK_CYC)) u_brown_win (
        .clk   (clk),
        .rst_b (rst_b),
        .start (brown_start),
        .stop  (brown_set),
        .open  (brown_open)
    );

    // The unlock bit itself is this window: it drops after four cycles or on select
    mpcr_window #(.LEN(UNLOCK_CYC)) u_vunlk_win (
        .clk   (clk),
        .rst_b (rst_b),
        .start (vunlk_start),
        .stop  (vsel_write), // [RL13]
        .open  (vunlk_open)
    );

    // Timer two is only gated while it runs from the core clock
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gate
            if (gi == CG_TIMER_TWO) begin : g_t2
                assign gate_eff[gi] = gate_reg[gi] && !timer_two_async_select; // [RL16]
            end else begin : g_plain
                assign gate_eff[gi] = gate_reg[gi]; // [RL15]
            end
        end
    endgenerate

    always_comb begin
        sleep_ctrl_next = sleep_ctrl_reg;
        dbg_off_next    = dbg_off_reg;
        dbg_pend_next   = dbg_pend_reg;
        brown_off_next  = brown_off_reg;
        brown_age_next  = brown_age_reg;
        pull_off_next   = pull_off_reg;
        vsel_next       = vsel_reg;
        vec_state_next  = vec_state_reg;
        gate_next       = gate_reg;

        // Sleep control; reserved codes are stored and passed to sleep_mode unchanged
        if (wr_sc) begin
            sleep_ctrl_next = wd[SC_MODE_MSB:SC_ENABLE_BIT]; // [RL23]
        end

        if (dbg_start) begin
            dbg_pend_next = wd[MC_DBG_OFF];
        end
        if (dbg_done) begin
            dbg_off_next = dbg_pend_reg; // [RL5]
        end

        // Self-clearing after three cycles; a new set restarts the count
        if (brown_set) begin
            brown_off_next = 1'b1; // [RL6]
            brown_age_next = 2'h0;
        end else if (brown_off_reg) begin
            brown_age_next = brown_age_reg + 2'h1;
            if (brown_age_reg == BROWN_LIFE_LAST) begin
                brown_off_next = 1'b0; // [RL8]
                brown_age_next = 2'h0;
            end
        end

        if (wr_mc) begin
            pull_off_next = wd[MC_PULL_OFF]; // [RL9]
        end
        if (vsel_write) begin
            vsel_next = wd[MC_VSEL]; // [RL10]
        end

        // Interrupt blocking across the vector change sequence
        case (vec_state_reg)
            MPCR_VEC_IDLE: begin
                if (vunlk_start) begin
                    vec_state_next = MPCR_VEC_ARMED; // [RL12]
                end
            end
            MPCR_VEC_ARMED: begin
                if (vsel_write) begin
                    vec_state_next = MPCR_VEC_HOLD;
                end else if (!vunlk_open && !vunlk_start) begin
                    vec_state_next = MPCR_VEC_IDLE; // [RL12]
                end
            end
            MPCR_VEC_HOLD: begin
                if (vunlk_start) begin
                    vec_state_next = MPCR_VEC_ARMED;
                end else if (instr_retire) begin
                    vec_state_next = MPCR_VEC_IDLE; // [RL12]
                end
            end
            default: begin
                vec_state_next = MPCR_VEC_IDLE;
            end
        endcase

        if (wr_cg) begin
            gate_next = wd; // [RL15]
        end
    end

    // Shadowing the bit: it counts as in force only three cycles after set
    assign brown_pipe_next = {brown_pipe_reg[BROWN_DELAY_CYC-2:0], brown_off_reg}; // [RL7]

    always_comb begin
        // Readback; bits 3 and 2 of mcu_control are not stored
        case (data_addr)
            SLEEP_CTRL_ADDR: rd_data_next = {4'h0, sleep_ctrl_reg};
            MCU_CTRL_ADDR:   rd_data_next = {dbg_off_reg, brown_off_reg, brown_open,
                                             pull_off_reg, 2'b00, vsel_reg, vunlk_open}; // [RL24]
            CLK_GATE_ADDR:   rd_data_next = gate_reg;
            default:         rd_data_next = 8'h00;
        endcase
        if (!bus.rd) begin
            rd_data_next = 8'h00;
        end

        sleep_go_next    = sleep_instr && sleep_ctrl_reg[SC_ENABLE_BIT]; // [RL1]
        brown_sleep_next = sleep_go_next && brown_pipe_reg[BROWN_DELAY_CYC-1]; // [RL7]
        dbg_en_next      = fuse.debug_port_fuse && !dbg_off_reg; // [RL4]

        // Section protection blocks interrupts without touching the global flag
        irq_block_next = (vec_state_next != MPCR_VEC_IDLE)
                       || (vsel_reg && fuse.app_protect_lock && !exec_in_boot)
                       || (!vsel_reg && fuse.boot_protect_lock && exec_in_boot); // [RL14]

        // Gating only freezes the clock, so timer state survives a stop
        clk_stop_next = gate_eff; // [RL17]
        cmp_ok_next   = !gate_reg[0]; // [RL19]
    end

    // All control state takes constants under the merged reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_ctrl_reg  <= SLEEP_CTRL_RESET; // [RL20]
            dbg_off_reg     <= 1'b0;
            dbg_pend_reg    <= 1'b0;
            brown_off_reg   <= 1'b0;
            brown_age_reg   <= 2'h0;
            brown_pipe_reg  <= '0;
            pull_off_reg    <= 1'b0;
            vsel_reg        <= 1'b0;
            vec_state_reg   <= MPCR_VEC_IDLE;
            gate_reg        <= CLK_GATE_RESET;
            rd_data_reg     <= 8'h00;
            sleep_go_reg    <= 1'b0;
            brown_sleep_reg <= 1'b0;
            dbg_en_reg      <= 1'b0;
            irq_block_reg   <= 1'b0;
            clk_stop_reg    <= 8'h00;
            cmp_ok_reg      <= 1'b1;
            port_rst_reg    <= 1'b0; // [RL21]
        end else begin
            sleep_ctrl_reg  <= sleep_ctrl_next;
            dbg_off_reg     <= dbg_off_next;
            dbg_pend_reg    <= dbg_pend_next;
            brown_off_reg   <= brown_off_next;
            brown_age_reg   <= brown_age_next;
            brown_pipe_reg  <= brown_pipe_next;
            pull_off_reg    <= pull_off_next;
            vsel_reg        <= vsel_next;
            vec_state_reg   <= vec_state_next;
            gate_reg        <= gate_next;
            rd_data_reg     <= rd_data_next;
            sleep_go_reg    <= sleep_go_next;
            brown_sleep_reg <= brown_sleep_next;
            dbg_en_reg      <= dbg_en_next;
            irq_block_reg   <= irq_block_next;
            clk_stop_reg    <= clk_stop_next;
            cmp_ok_reg      <= cmp_ok_next;
            port_rst_reg    <= 1'b1;
        end
    end

    mpcr_rst_stretch u_stretch (
        .clk        (clk),
        .rst_b      (rst_b),
        .sel        (fuse.startup_sel),
        .short_cyc  (TOUT_SHORT_CYC),
        .long_cyc   (TOUT_LONG_CYC),
        .core_rst_b (core_rst_b) // [RL22]
    );

    assign rd_data             = rd_data_reg;
    assign sleep_go            = sleep_go_reg;
    assign sleep_mode          = mpcr_sleep_e'(sleep_ctrl_reg[SC_MODE_MSB:SC_MODE_LSB]);
    assign brownout_sleep_off  = brown_sleep_reg;
    assign debug_port_enable   = dbg_en_reg;
    assign pullup_global_off   = pull_off_reg;
    assign vector_table_select = vsel_reg;
    assign irq_block           = irq_block_reg;
    assign clock_stop          = clk_stop_reg;
    assign comparator_mux_ok   = cmp_ok_reg;
    assign port_rst_b          = port_rst_reg;
endmodule

// File: verification/mpcr_asserts.sv
// Port checker for the system control block, bound into every mpcr_top.
// Assumes the lock fuses stay low except while section blocking is exercised.
`timescale 1ns/1ns
module mpcr_asserts
    import mpcr_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Inputs
    input wire mpcr_bus_s   bus,
    input wire logic        sleep_instr,
    input wire logic        instr_retire,
    input wire logic        exec_in_boot,
    input wire mpcr_fuse_s  fuse,
    input wire logic        timer_two_async_select,
    // Outputs
    input wire logic [7:0]  rd_data,
    input wire logic        sleep_go,
    input wire mpcr_sleep_e sleep_mode,
    input wire logic        brownout_sleep_off,
    input wire logic        debug_port_enable,
    input wire logic        pullup_global_off,
    input wire logic        vector_table_select,
    input wire logic        irq_block,
    input wire logic [7:0]  clock_stop,
    input wire logic        comparator_mux_ok,
    input wire logic        core_rst_b,
    input wire logic        port_rst_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sleep_cause_a: assert property (sleep_go |-> $past(sleep_instr))
        else $error("sleep entered without a sleep instruction");
    brown_with_sleep_a: assert property (brownout_sleep_off |-> sleep_go)
        else $error("brown-out off outside a sleep entry");
    rd_idle_zero_a: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
        else $error("read data not zero without a read");
    mode_by_write_a: assert property (!$stable(sleep_mode) |-> $past(bus.wr))
        else $error("sleep mode changed without a write");
    pull_by_write_a: assert property (!$stable(pullup_global_off) |->
        $past(bus.wr) && $past(bus.wdata[MC_PULL_OFF]) == pullup_global_off)
        else $error("pull-up off changed without a matching write");
    vsel_by_write_a: assert property (!$stable(vector_table_select) |->
        $past(bus.wr && !bus.wdata[MC_VUNLK]) && $past(bus.wdata[MC_VSEL]) == vector_table_select)
        else $error("vector select changed outside the unlock sequence");
    irq_rise_a: assert property ($rose(irq_block) && !fuse.app_protect_lock
        && !fuse.boot_protect_lock |-> $past(bus.wr && bus.wdata[MC_VUNLK]))
        else $error("interrupt block rose without an unlock write");
    debug_fuse_a: assert property (!fuse.debug_port_fuse |=> !debug_port_enable)
        else $error("debug port enabled with fuse unprogrammed");
    timer_async_a: assert property ($past(timer_two_async_select) &&
        timer_two_async_select |-> !clock_stop[CG_TIMER_TWO])
        else $error("timer two stopped while on its own clock");
    comp_mux_a: assert property (comparator_mux_ok != clock_stop[0])
        else $error("comparator mux access disagrees with converter stop");
    port_reset_a: assert property (disable iff (1'b0) !rst_b |-> !port_rst_b && !core_rst_b)
        else $error("reset outputs high during reset");
    fast_tout_a: assert property ($rose(port_rst_b) && fuse.startup_sel == TOUT_SEL_FAST
        |-> !core_rst_b ##[3:7] core_rst_b)
        else $error("fast time-out not honoured");
endmodule

bind mpcr_top mpcr_asserts
    u_asserts (.clk(clk), .rst_b(rst_b), .bus(bus), .sleep_instr(sleep_instr),
    .instr_retire(instr_retire), .exec_in_boot(exec_in_boot), .fuse(fuse),
    .timer_two_async_select(timer_two_async_select), .rd_data(rd_data), .sleep_go(sleep_go),
    .sleep_mode(sleep_mode), .brownout_sleep_off(brownout_sleep_off),
    .debug_port_enable(debug_port_enable), .pullup_global_off(pullup_global_off),
    .vector_table_select(vector_table_select), .irq_block(irq_block),
    .clock_stop(clock_stop), .comparator_mux_ok(comparator_mux_ok),
    .core_rst_b(core_rst_b), .port_rst_b(port_rst_b));

// File: verification/testbench.sv
// Self-checking bench for the system control block.
// Assumes the shortened reset time-outs of 20 and 40 cycles.
`timescale 1ns/1ns
module testbench;
    import mpcr_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b1;
    mpcr_bus_s   bus = '0;
    mpcr_fuse_s  fuse = '{1'b1, 1'b0, 1'b0, 2'h0};
    logic        sleep_instr = 1'b0, instr_retire = 1'b0, exec_in_boot = 1'b0, t2_async = 1'b0;
    logic [7:0]  rd_data, clock_stop;
    mpcr_sleep_e sleep_mode;
    logic        sleep_go, bos, dpe, pgo, vts, irqb, cmok, core_rst_b, port_rst_b;
    int          failures = 0, check_count = 0, d, a, n;

    mpcr_top #(.TOUT_SHORT_CYC(20), .TOUT_LONG_CYC(40)) u_dut (
        .clk(clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
        .sleep_instr(sleep_instr), .instr_retire(instr_retire), .exec_in_boot(exec_in_boot),
        .fuse(fuse), .timer_two_async_select(t2_async), .sleep_go(sleep_go),
        .sleep_mode(sleep_mode), .brownout_sleep_off(bos), .debug_port_enable(dpe),
        .pullup_global_off(pgo), .vector_table_select(vts), .irq_block(irqb),
        .clock_stop(clock_stop), .comparator_mux_ok(cmok), .core_rst_b(core_rst_b),
        .port_rst_b(port_rst_b));

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; signals stand until the next call
    task automatic put(input logic [7:0] ad, input logic io, w, r, input logic [7:0] wd);
        bus = '{ad, io, w, r, wd};
        @(posedge clk);
        #1;
    endtask

    task automatic idle(input int cyc);
        repeat (cyc) put(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [7:0] ad, input logic io, input logic [7:0] exp);
        put(ad, io, 1'b0, 1'b1, 8'h00);
        chk("read data", exp, rd_data);
        idle(1);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        put(ad, 1'b0, 1'b1, 1'b0, wd);
    endtask

    task automatic pulse_sleep();
        sleep_instr = 1'b1;
        @(posedge clk);
        #1 sleep_instr = 1'b0;
    endtask

    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    initial begin
        void'($urandom(99729));
        #1 rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        rd(SLEEP_CTRL_ADDR, 1'b0, 8'h00);
        rd(MCU_CTRL_ADDR, 1'b0, 8'h00);
        rd(CLK_GATE_ADDR, 1'b0, CLK_GATE_RESET);
        rd(8'h60, 1'b0, 8'h00);
        chk("mux ok", 8'h01, {7'h0, cmok});
        // Every sleep code, through both address spaces; code 5 left disabled
        for (int m = 0; m < 8; m++) begin
            d = (m << 1) | (m != 5);
            put(m[0] ? SLEEP_CTRL_ADDR - IO_TO_DATA_OFS : SLEEP_CTRL_ADDR, m[0], 1'b1, 1'b0,
                d[7:0]);
            idle(1);
            chk("sleep mode", m[7:0], {5'h0, sleep_mode});
            pulse_sleep();
            chk("sleep go", {7'h0, m != 5}, {7'h0, sleep_go});
            rd(SLEEP_CTRL_ADDR, 1'b0, d[7:0]);
        end
        repeat (6) begin
            d = $urandom % 256;
            a = $urandom % 2;
            t2_async = a[0];
            wr(CLK_GATE_ADDR, d[7:0]);
            idle(2);
            chk("clock stop", d[7:0] & ~(a[7:0] << CG_TIMER_TWO), clock_stop);
            chk("mux ok", {7'h0, ~d[0]}, {7'h0, cmok});
            rd(CLK_GATE_ADDR, 1'b0, d[7:0]);
        end
        // The I/O form cannot reach extended space
        put(CLK_GATE_ADDR - IO_TO_DATA_OFS, 1'b1, 1'b1, 1'b0, ~d[7:0]);
        rd(CLK_GATE_ADDR, 1'b0, d[7:0]);
        put(MCU_CTRL_ADDR - IO_TO_DATA_OFS, 1'b1, 1'b1, 1'b0, 8'h1C);
        idle(1);
        chk("pull-up off", 8'h01, {7'h0, pgo});
        rd(MCU_CTRL_ADDR - IO_TO_DATA_OFS, 1'b1, 8'h10);
        // Vector move: unlock then select on the next cycle
        wr(MCU_CTRL_ADDR, 8'h11);
        wr(MCU_CTRL_ADDR, 8'h12);
        chk("irq block", 8'h01, {7'h0, irqb});
        idle(2);
        chk("vector select", 8'h01, {7'h0, vts});
        chk("irq block held", 8'h01, {7'h0, irqb});
        instr_retire = 1'b1;
        @(posedge clk);
        #1 instr_retire = 1'b0;
        idle(1);
        chk("irq block end", 8'h00, {7'h0, irqb});
        wr(MCU_CTRL_ADDR, 8'h10);
        idle(1);
        chk("vector select", 8'h01, {7'h0, vts});
        wr(MCU_CTRL_ADDR, 8'h11);
        idle(6);
        chk("irq block timeout", 8'h00, {7'h0, irqb});
        rd(MCU_CTRL_ADDR, 1'b0, 8'h12);
        fuse.app_protect_lock = 1'b1;
        idle(2);
        chk("irq block app", 8'h01, {7'h0, irqb});
        exec_in_boot = 1'b1;
        idle(2);
        chk("irq block boot", 8'h00, {7'h0, irqb});
        fuse.app_protect_lock = 1'b0;
        exec_in_boot = 1'b0;
        // Brown-out sleep bit: refused alone, set after unlock, then self-clears
        wr(MCU_CTRL_ADDR, 8'h52);
        rd(MCU_CTRL_ADDR, 1'b0, 8'h12);
        wr(MCU_CTRL_ADDR, 8'h72);
        wr(MCU_CTRL_ADDR, 8'h52);
        put(MCU_CTRL_ADDR, 1'b0, 1'b0, 1'b1, 8'h00);
        chk("brown-out bit", 8'h40, rd_data & 8'h40);
        idle(2);
        pulse_sleep();
        chk("brown sleep", 8'h01, {7'h0, bos});
        rd(MCU_CTRL_ADDR, 1'b0, 8'h12);
        // Debug port disable needs two equal writes close together
        wr(MCU_CTRL_ADDR, 8'h92);
        idle(6);
        chk("debug enable", 8'h01, {7'h0, dpe});
        rd(MCU_CTRL_ADDR, 1'b0, 8'h12);
        wr(MCU_CTRL_ADDR, 8'h92);
        idle(1);
        wr(MCU_CTRL_ADDR, 8'h92);
        idle(2);
        chk("debug enable", 8'h00, {7'h0, dpe});
        rd(MCU_CTRL_ADDR, 1'b0, 8'h92);
        // Second reset in mid-cycle, short time-out, fuse now unprogrammed
        fuse = '{1'b0, 1'b0, 1'b0, TOUT_SEL_SHORT};
        rst_b = 1'b0;
        #1;
        chk("port reset", 8'h00, {7'h0, port_rst_b});
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("core reset early", 8'h00, {7'h0, core_rst_b});
        n = 0;
        while (core_rst_b !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        chk("core reset late", 8'h01, {7'h0, core_rst_b});
        chk("debug enable", 8'h00, {7'h0, dpe});
        rd(MCU_CTRL_ADDR, 1'b0, 8'h00);
        rd(CLK_GATE_ADDR, 1'b0, 8'h00);
        end_of_test();
    end
endmodule
